// *** cmd_pkg.sv ***
package cmd_pkg;
    localparam int          PADDR_W          = 16;
    localparam int          DADDR_W          = 11;
    localparam logic [15:0] PROG_TOP         = 16'hFFFF;
    localparam logic [15:0] RESET_VEC_ADDR   = 16'hFFFE;
    localparam logic [15:0] IRQ_VEC_BASE     = 16'hFFE0;
    localparam logic [15:0] TABLE_CALL_BASE  = 16'hFFC0;
    localparam logic [15:0] PAGE_CALL_BASE   = 16'hFF00;
    localparam logic [15:0] PAGE_CALL_LIMIT  = 16'hFFFF;
    localparam logic [15:0] SIZE_24K         = 16'h6000;
    localparam logic [15:0] SIZE_32K         = 16'h8000;
    localparam logic [15:0] SIZE_48K         = 16'hC000;
    localparam logic [1:0]  VAR_24K          = 2'h0;
    localparam logic [1:0]  VAR_32K          = 2'h1;
    localparam logic [1:0]  VAR_48K          = 2'h2;
    localparam logic [3:0]  TABLE_IDX_MAX    = 4'hF;
    localparam int          IRQ_SRCS         = 15;
    localparam logic [10:0] RAM_SIZE         = 11'h600;
    localparam logic [7:0]  CTRL_LO          = 8'hC0;
    localparam logic [7:0]  CTRL_HI          = 8'hFF;
    // Page one after reset, so setting the flag alone reaches 100 to 1FF.
    localparam logic [2:0]  PAGE_RESET       = 3'h1;
    localparam logic [7:0]  UNMAPPED_DATA    = 8'hFF;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_VEC_LO = 5'b00010,
        ST_VEC_HI = 5'b00100,
        ST_JUMP   = 5'b01000,
        ST_WAIT   = 5'b10000
    } cmd_state_t;
endpackage : cmd_pkg

// *** cmd_mem_if.sv ***
`timescale 1ns/1ps
interface cmd_mem_if;
    logic        we;
    logic [10:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface : cmd_mem_if

// *** cmd_ram.sv ***
`timescale 1ns/1ps
module cmd_ram (
    input  wire logic clk_in,
    cmd_mem_if.mem    bus
);
    logic [7:0] mem_reg [0:1535];

    always_ff @(posedge clk_in) begin
        if (bus.we) begin
            mem_reg[bus.addr] <= bus.wdata;
        end
    end

    // Read data comes out of a register.
    always_ff @(posedge clk_in) begin
        bus.rdata <= mem_reg[bus.addr];
    end
endmodule : cmd_ram

// *** cmd_map_decode.sv ***
// How it works
// - Program counter is 16 bits, 64K span, increments wrap to zero.
// - 24, 32 or 48K of program memory is present per variant, plus the FF00 page.
// - After reset the counter loads from the vector at FFFE/FFFF.
// - Each interrupt source has a two-byte vector from FFE0 upward.
// - Low entries: interval timer, watch/watchdog, A/D, timers 4 to 0.
// - High entries: serial, UART1, UART0, external 3 to 0, then reset.
// - Table call n vectors through FFC0 plus two times (15 minus n).
// - Page call is two bytes, offset into the FF00 page.
// - Unused vector locations in the top page read as program memory.
// - User RAM is 1.5K in pages chosen by the page select register.
// - With the direct-page flag clear, direct access reaches page zero.
// - Control registers decode in data addresses C0 to FF.
// - Unimplemented control addresses read arbitrary data, writes undefined.
// - Flag clear covers 00-FF, flag set covers 100-1FF before paging.
`timescale 1ns/1ps
module cmd_map_decode (
    input  wire logic        CLOCK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic [1:0]  VARIANT_IN,
    input  wire logic        PC_INC_IN,
    input  wire logic        IRQ_TAKE_IN,
    input  wire logic [3:0]  IRQ_SRC_IN,
    input  wire logic        TABLE_CALL_IN,
    input  wire logic [3:0]  TABLE_IDX_IN,
    input  wire logic        PAGE_CALL_IN,
    input  wire logic [7:0]  PAGE_OFS_IN,
    input  wire logic        PROG_DATA_VALID_IN,
    input  wire logic [7:0]  PROG_DATA_IN,
    input  wire logic        SET_DP_IN,
    input  wire logic        CLR_DP_IN,
    input  wire logic        PAGE_WR_IN,
    input  wire logic [2:0]  PAGE_IN,
    input  wire logic        DATA_REQ_IN,
    input  wire logic        DATA_WE_IN,
    input  wire logic        DATA_DIRECT_IN,
    input  wire logic [10:0] DATA_ADDR_IN,
    input  wire logic [7:0]  DATA_WDATA_IN,
    input  wire logic [7:0]  CTRL_RDATA_IN,
    output logic [15:0]      PC_OUT,
    output logic             FETCH_PRESENT_OUT,
    output logic             VEC_BUSY_OUT,
    output logic [15:0]      VEC_ADDR_OUT,
    output logic             VEC_RD_OUT,
    output logic             DIRECT_PAGE_OUT,
    output logic [2:0]       RAM_PAGE_OUT,
    output logic [10:0]      DATA_EADDR_OUT,
    output logic             CTRL_SEL_OUT,
    output logic             CTRL_WE_OUT,
    output logic [7:0]       DATA_RDATA_OUT,
    output logic             DATA_RVALID_OUT
);
    cmd_mem_if ram_bus ();

    cmd_pkg::cmd_state_t state_reg;
    cmd_pkg::cmd_state_t state_next;
    logic [15:0] pc_reg;
    logic [15:0] vec_reg;
    logic [7:0]  lo_reg;
    logic        dp_reg;
    logic [2:0]  page_reg;
    logic [15:0] prog_size;
    logic [10:0] eaddr;
    logic        ctrl_hit;
    logic        ram_hit;
    logic        rd_pend_reg;
    logic        rd_ram_reg;
    logic [7:0]  ctrl_data_reg;

    always_comb begin
        case (VARIANT_IN)
            cmd_pkg::VAR_24K: prog_size = cmd_pkg::SIZE_24K;
            cmd_pkg::VAR_32K: prog_size = cmd_pkg::SIZE_32K;
            default:          prog_size = cmd_pkg::SIZE_48K;
        endcase
    end

    // Present memory sits at the bottom; the top page is always backed so that
    // unused vector and table-call slots stay usable as program bytes.
    assign FETCH_PRESENT_OUT = (pc_reg < prog_size)
                             || (pc_reg >= cmd_pkg::PAGE_CALL_BASE);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cmd_pkg::ST_IDLE: begin
                if (IRQ_TAKE_IN || TABLE_CALL_IN) begin
                    state_next = cmd_pkg::ST_VEC_LO;
                end
            end
            cmd_pkg::ST_VEC_LO: begin
                if (PROG_DATA_VALID_IN) begin
                    state_next = cmd_pkg::ST_VEC_HI;
                end
            end
            cmd_pkg::ST_VEC_HI: begin
                if (PROG_DATA_VALID_IN) begin
                    state_next = cmd_pkg::ST_JUMP;
                end
            end
            cmd_pkg::ST_JUMP: state_next = cmd_pkg::ST_IDLE;
            default:          state_next = cmd_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            state_reg <= cmd_pkg::ST_VEC_LO;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            vec_reg <= cmd_pkg::RESET_VEC_ADDR;
        end else if (state_reg == cmd_pkg::ST_IDLE && IRQ_TAKE_IN) begin
            // Sources numbered 0 (interval timer) .. 14 (external 0) ascend.
            vec_reg <= cmd_pkg::IRQ_VEC_BASE + {11'h000, IRQ_SRC_IN, 1'b0};
        end else if (state_reg == cmd_pkg::ST_IDLE && TABLE_CALL_IN) begin
            vec_reg <= cmd_pkg::TABLE_CALL_BASE
                     + {11'h000, cmd_pkg::TABLE_IDX_MAX - TABLE_IDX_IN, 1'b0};
        end else if (state_reg == cmd_pkg::ST_VEC_LO && PROG_DATA_VALID_IN) begin
            vec_reg <= vec_reg + 16'h0001;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            lo_reg <= 8'h00;
        end else if (state_reg == cmd_pkg::ST_VEC_LO && PROG_DATA_VALID_IN) begin
            lo_reg <= PROG_DATA_IN;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            pc_reg <= 16'h0000;
        end else if (state_reg == cmd_pkg::ST_VEC_HI && PROG_DATA_VALID_IN) begin
            pc_reg <= {PROG_DATA_IN, lo_reg};
        end else if (state_reg == cmd_pkg::ST_IDLE && PAGE_CALL_IN) begin
            pc_reg <= {cmd_pkg::PAGE_CALL_BASE[15:8], PAGE_OFS_IN};
        end else if (state_reg == cmd_pkg::ST_IDLE && PC_INC_IN) begin
            pc_reg <= pc_reg + 16'h0001;
        end
    end

    assign PC_OUT       = pc_reg;
    assign VEC_ADDR_OUT = vec_reg;
    assign VEC_RD_OUT   = (state_reg == cmd_pkg::ST_VEC_LO)
                        || (state_reg == cmd_pkg::ST_VEC_HI);
    assign VEC_BUSY_OUT = (state_reg != cmd_pkg::ST_IDLE);

    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            dp_reg <= 1'b0;
        end else if (SET_DP_IN) begin
            dp_reg <= 1'b1;
        end else if (CLR_DP_IN) begin
            dp_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            page_reg <= cmd_pkg::PAGE_RESET;
        end else if (PAGE_WR_IN) begin
            page_reg <= PAGE_IN;
        end
    end

    assign DIRECT_PAGE_OUT = dp_reg;
    assign RAM_PAGE_OUT    = page_reg;

    // A direct access supplies only the low byte; the page comes from the flag
    // and the page select register, which takes effect once the flag is set.
    always_comb begin
        if (DATA_DIRECT_IN && dp_reg) begin
            eaddr = {page_reg, DATA_ADDR_IN[7:0]};
        end else if (DATA_DIRECT_IN) begin
            eaddr = {3'h0, DATA_ADDR_IN[7:0]};
        end else begin
            eaddr = DATA_ADDR_IN;
        end
    end

    assign ctrl_hit = (eaddr[10:8] == 3'h0)
                    && (eaddr[7:0] >= cmd_pkg::CTRL_LO)
                    && (eaddr[7:0] <= cmd_pkg::CTRL_HI);
    assign ram_hit  = !ctrl_hit && (eaddr < cmd_pkg::RAM_SIZE);

    assign DATA_EADDR_OUT = eaddr;
    assign CTRL_SEL_OUT   = DATA_REQ_IN && ctrl_hit;
    assign CTRL_WE_OUT    = DATA_REQ_IN && ctrl_hit && DATA_WE_IN;

    assign ram_bus.we    = DATA_REQ_IN && DATA_WE_IN && ram_hit;
    assign ram_bus.addr  = eaddr;
    assign ram_bus.wdata = DATA_WDATA_IN;

    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            rd_pend_reg   <= 1'b0;
            rd_ram_reg    <= 1'b0;
            ctrl_data_reg <= 8'h00;
        end else begin
            rd_pend_reg <= DATA_REQ_IN && !DATA_WE_IN;
            rd_ram_reg  <= ram_hit;
            // Unbacked addresses give a fixed filler, one legal arbitrary value.
            ctrl_data_reg <= ctrl_hit ? CTRL_RDATA_IN : cmd_pkg::UNMAPPED_DATA;
        end
    end

    assign DATA_RDATA_OUT  = rd_ram_reg ? ram_bus.rdata : ctrl_data_reg;
    assign DATA_RVALID_OUT = rd_pend_reg;

    cmd_ram u_ram (
        .clk_in (CLOCK_IN),
        .bus    (ram_bus)
    );
endmodule : cmd_map_decode

// *** cmd_map_decode_checker.sv ***
`timescale 1ns/1ps
module cmd_map_decode_checker (
    input wire logic        CLOCK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic [1:0]  VARIANT_IN,
    input wire logic        PC_INC_IN,
    input wire logic        IRQ_TAKE_IN,
    input wire logic [3:0]  IRQ_SRC_IN,
    input wire logic        TABLE_CALL_IN,
    input wire logic [3:0]  TABLE_IDX_IN,
    input wire logic        PAGE_CALL_IN,
    input wire logic [7:0]  PAGE_OFS_IN,
    input wire logic        PROG_DATA_VALID_IN,
    input wire logic        DATA_REQ_IN,
    input wire logic        DATA_WE_IN,
    input wire logic        DATA_DIRECT_IN,
    input wire logic [10:0] DATA_ADDR_IN,
    input wire logic [15:0] PC_OUT,
    input wire logic        FETCH_PRESENT_OUT,
    input wire logic        VEC_BUSY_OUT,
    input wire logic [15:0] VEC_ADDR_OUT,
    input wire logic        VEC_RD_OUT,
    input wire logic        DIRECT_PAGE_OUT,
    input wire logic [2:0]  RAM_PAGE_OUT,
    input wire logic [10:0] DATA_EADDR_OUT,
    input wire logic        CTRL_SEL_OUT,
    input wire logic        DATA_RVALID_OUT
);
    logic        quiet;
    logic [15:0] size;
    logic        dreq;
    assign quiet = !VEC_BUSY_OUT && !IRQ_TAKE_IN && !TABLE_CALL_IN;
    assign size  = (VARIANT_IN == 2'h0) ? 16'h6000 : (VARIANT_IN == 2'h1) ? 16'h8000 : 16'hC000;
    assign dreq  = DATA_REQ_IN && DATA_DIRECT_IN;
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);
    a_pc_wrap: assert property (quiet && !PAGE_CALL_IN && PC_INC_IN
        |=> PC_OUT == $past(PC_OUT) + 16'h1) else $error("pc step wrong");
    a_fetch_present: assert property (FETCH_PRESENT_OUT
        == (PC_OUT < size || PC_OUT >= 16'hFF00)) else $error("presence wrong");
    a_reset_vector: assert property ($fell(SYS_RST_IN)
        |-> VEC_RD_OUT && VEC_ADDR_OUT == 16'hFFFE) else $error("reset vector wrong");
    a_irq_vector: assert property (!VEC_BUSY_OUT && IRQ_TAKE_IN
        |=> VEC_RD_OUT && VEC_ADDR_OUT == 16'hFFE0 + {$past(IRQ_SRC_IN), 1'b0})
        else $error("irq vector wrong");
    a_table_vector: assert property (!VEC_BUSY_OUT && !IRQ_TAKE_IN && TABLE_CALL_IN
        |=> VEC_ADDR_OUT == 16'hFFC0 + {~$past(TABLE_IDX_IN), 1'b0}) else $error("table vector");
    a_page_call: assert property (quiet && !TABLE_CALL_IN && PAGE_CALL_IN
        |=> PC_OUT == {8'hFF, $past(PAGE_OFS_IN)}) else $error("page call wrong");
    a_byte_order: assert property (VEC_RD_OUT && PROG_DATA_VALID_IN && !VEC_ADDR_OUT[0]
        |=> VEC_RD_OUT && VEC_ADDR_OUT == $past(VEC_ADDR_OUT) + 16'h1) else $error("byte order");
    a_ctrl_window: assert property (DATA_REQ_IN
        |-> CTRL_SEL_OUT == (DATA_EADDR_OUT[10:6] == 5'h03)) else $error("control window");
    a_page_zero: assert property (dreq && !DIRECT_PAGE_OUT
        |-> DATA_EADDR_OUT == {3'h0, DATA_ADDR_IN[7:0]}) else $error("page zero wrong");
    a_page_sel: assert property (dreq && DIRECT_PAGE_OUT
        |-> DATA_EADDR_OUT == {RAM_PAGE_OUT, DATA_ADDR_IN[7:0]}) else $error("paging wrong");
    a_read_valid: assert property (DATA_REQ_IN && !DATA_WE_IN |=> DATA_RVALID_OUT)
        else $error("read valid missing");
endmodule : cmd_map_decode_checker

// *** cmd_prog_model.sv ***
`timescale 1ns/1ps
module cmd_prog_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        rd_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] tgt_in,
    output logic             valid_out = 1'b0,
    output logic [7:0]       data_out = 8'h00
);
    // Each byte is scrambled with its address so a wrong fetch address shows up.
    always @(posedge clk_in) begin
        if (rd_in && !valid_out && !rst_in) begin
            valid_out <= 1'b1;
            data_out  <= (addr_in[0] ? tgt_in[15:8] : tgt_in[7:0]) ^ addr_in[7:0];
        end else begin
            valid_out <= 1'b0;
            data_out  <= ~data_out;
        end
    end
endmodule : cmd_prog_model

// *** tb_cmd_map_decode.sv ***
`timescale 1ns/1ps
module tb_cmd_map_decode;
    logic CLOCK_IN = 1'b0, SYS_RST_IN = 1'b1, PC_INC_IN = 1'b0, IRQ_TAKE_IN = 1'b0;
    logic TABLE_CALL_IN = 1'b0, PAGE_CALL_IN = 1'b0, SET_DP_IN = 1'b0, CLR_DP_IN = 1'b0;
    logic PAGE_WR_IN = 1'b0, DATA_REQ_IN = 1'b0, DATA_WE_IN = 1'b0, DATA_DIRECT_IN = 1'b0;
    logic [1:0] VARIANT_IN = 2'h0;
    logic [3:0] IRQ_SRC_IN = 4'h0, TABLE_IDX_IN = 4'h0;
    logic [7:0] PAGE_OFS_IN = 8'h00, DATA_WDATA_IN = 8'h00, PROG_DATA_IN, DATA_RDATA_OUT;
    logic [7:0] CTRL_RDATA_IN = 8'h00;
    logic [2:0] PAGE_IN = 3'h0, RAM_PAGE_OUT;
    logic [10:0] DATA_ADDR_IN = 11'h000, DATA_EADDR_OUT;
    logic [15:0] PC_OUT, VEC_ADDR_OUT, prog_target = 16'h1234;
    logic PROG_DATA_VALID_IN, FETCH_PRESENT_OUT, VEC_BUSY_OUT, VEC_RD_OUT, DIRECT_PAGE_OUT;
    logic CTRL_SEL_OUT, CTRL_WE_OUT, DATA_RVALID_OUT;
    int   bad_count = 0, total_checks = 0, cycles = 0;
    logic [1:0] ctrl_seen = 2'h0;
    cmd_map_decode u_cmd_map_decode (.*);
    cmd_prog_model u_cmd_prog_model (.clk_in(CLOCK_IN), .rst_in(SYS_RST_IN), .rd_in(VEC_RD_OUT),
        .addr_in(VEC_ADDR_OUT), .tgt_in(prog_target), .valid_out(PROG_DATA_VALID_IN),
        .data_out(PROG_DATA_IN));
    initial forever #12.5 CLOCK_IN = ~CLOCK_IN;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [15:0] ex(input logic [15:0] t, input logic [15:0] v);
        return t ^ {v[7:0] + 8'h01, v[7:0]};
    endfunction : ex
    task automatic wait_idle();
        for (int n = 0; n < 20 && VEC_BUSY_OUT !== 1'b0 || n == 0; n++) begin
            @(posedge CLOCK_IN);
            #1;
        end
        chk(VEC_BUSY_OUT, 16'h0);
    endtask : wait_idle
    task automatic jump(input logic [15:0] t, input logic irq, input logic [3:0] k);
        @(posedge CLOCK_IN);
        prog_target <= t;
        IRQ_TAKE_IN <= irq;
        TABLE_CALL_IN <= !irq;
        IRQ_SRC_IN <= k;
        TABLE_IDX_IN <= k;
        @(posedge CLOCK_IN);
        IRQ_TAKE_IN <= 1'b0;
        TABLE_CALL_IN <= 1'b0;
        wait_idle();
    endtask : jump
    task automatic step_pc();
        @(posedge CLOCK_IN);
        PC_INC_IN <= 1'b1;
        @(posedge CLOCK_IN);
        PC_INC_IN <= 1'b0;
        #1;
    endtask : step_pc
    task automatic t_vectors();
        for (int s = 0; s < 15; s++) begin
            jump(16'h2000 + 16'(s), 1'b1, 4'(s));
            chk(PC_OUT, ex(16'h2000 + 16'(s), 16'hFFE0 + 16'(2 * s)));
        end
        for (int n = 0; n < 16; n++) begin
            jump(16'h3000, 1'b0, 4'(n));
            chk(PC_OUT, ex(16'h3000, 16'hFFC0 + 16'(2 * (15 - n))));
        end
        $display("vector test done");
    endtask : t_vectors
    task automatic t_present();
        logic [15:0] sz;
        for (int v = 0; v < 4; v++) begin
            sz = (v == 0) ? 16'h6000 : (v == 1) ? 16'h8000 : 16'hC000;
            @(posedge CLOCK_IN);
            VARIANT_IN <= 2'(v);
            jump(ex(sz - 16'h1, 16'hFFC0), 1'b0, 4'hF);
            chk(FETCH_PRESENT_OUT, 16'h1);
            step_pc();
            chk(PC_OUT, sz);
            chk(FETCH_PRESENT_OUT, 16'h0);
        end
        @(posedge CLOCK_IN);
        PAGE_CALL_IN <= 1'b1;
        PAGE_OFS_IN <= 8'hFF;
        @(posedge CLOCK_IN);
        PAGE_CALL_IN <= 1'b0;
        #1;
        chk(PC_OUT, 16'hFFFF);
        chk(FETCH_PRESENT_OUT, 16'h1);
        step_pc();
        chk(PC_OUT, 16'h0000);
        $display("program space test done");
    endtask : t_present
    task automatic acc(input logic we, input logic dir, input logic [10:0] a, input logic [7:0] d);
        @(posedge CLOCK_IN);
        DATA_REQ_IN <= 1'b1;
        DATA_WE_IN <= we;
        DATA_DIRECT_IN <= dir;
        DATA_ADDR_IN <= a;
        DATA_WDATA_IN <= d;
        #1;
        ctrl_seen = {CTRL_SEL_OUT, CTRL_WE_OUT};
        @(posedge CLOCK_IN);
        DATA_REQ_IN <= 1'b0;
        #1;
    endtask : acc
    task automatic rd(input logic dir, input logic [10:0] a, input logic [7:0] exp);
        acc(1'b0, dir, a, 8'h00);
        chk(DATA_RVALID_OUT, 16'h1);
        chk(DATA_RDATA_OUT, exp);
    endtask : rd
    task automatic t_data();
        @(posedge CLOCK_IN);
        SET_DP_IN <= 1'b1;
        @(posedge CLOCK_IN);
        SET_DP_IN <= 1'b0;
        acc(1'b1, 1'b1, 11'h020, 8'h66);
        rd(1'b0, 11'h120, 8'h66);
        @(posedge CLOCK_IN);
        CLR_DP_IN <= 1'b1;
        @(posedge CLOCK_IN);
        CLR_DP_IN <= 1'b0;
        acc(1'b1, 1'b1, 11'h010, 8'h5A);
        chk(ctrl_seen, 16'h0);
        @(posedge CLOCK_IN);
        PAGE_WR_IN <= 1'b1;
        PAGE_IN <= 3'h3;
        @(posedge CLOCK_IN);
        PAGE_WR_IN <= 1'b0;
        rd(1'b1, 11'h010, 8'h5A);
        @(posedge CLOCK_IN);
        SET_DP_IN <= 1'b1;
        @(posedge CLOCK_IN);
        SET_DP_IN <= 1'b0;
        acc(1'b1, 1'b1, 11'h010, 8'hA5);
        rd(1'b0, 11'h310, 8'hA5);
        rd(1'b0, 11'h010, 8'h5A);
        @(posedge CLOCK_IN);
        CLR_DP_IN <= 1'b1;
        CTRL_RDATA_IN <= 8'h3C;
        @(posedge CLOCK_IN);
        CLR_DP_IN <= 1'b0;
        rd(1'b1, 11'h010, 8'h5A);
        rd(1'b0, 11'h7FF, 8'hFF);
        acc(1'b1, 1'b0, 11'h0C1, 8'h0F);
        chk(ctrl_seen, 16'h3);
        rd(1'b1, 11'h0C1, 8'h3C);
        chk(ctrl_seen, 16'h2);
        $display("data test done");
    endtask : t_data
    always @(posedge CLOCK_IN) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge CLOCK_IN);
        SYS_RST_IN <= 1'b0;
        wait_idle();
        chk(PC_OUT, ex(16'h1234, 16'hFFFE));
        t_vectors();
        t_present();
        t_data();
        finish_test();
    end
endmodule : tb_cmd_map_decode
bind cmd_map_decode cmd_map_decode_checker u_cmd_map_decode_checker (.*);
